//--- psu_pkg.sv
package psu_pkg;
  // Clock and millisecond timebase
  localparam int CLK_PERIOD_PS = 5000;
  localparam int MS_PS         = 1000000000;
  localparam int CYC_PER_MS    = MS_PS / CLK_PERIOD_PS;
  localparam int MSW           = 11;

  // Documented times in ms
  localparam int INOK_ON_START_MAX_MS = 1800;
  localparam int INOK_ON_DIP_MAX_MS   = 100;
  localparam int INOK_V1_MIN_MS       = 7;
  localparam int INOK_VSB_MIN_MS      = 27;
  localparam int V1_DROP_MIN_MS       = 12;
  localparam int VSB_DROP_MIN_MS      = 40;
  localparam int OFF_MIN_MS           = 1000;
  localparam int OFF_MAX_MS           = 1200;
  localparam int PSON_ON_MIN_MS       = 190;
  localparam int PSON_ON_MAX_MS       = 220;
  localparam int PWOK_ON_MIN_MS       = 250;
  localparam int PWOK_ON_MAX_MS       = 350;
  localparam int BLINK_PERIOD_MS      = 1500;

  // Counts in ms ticks
  localparam logic [MSW-1:0] INOK_ON_CNT = MSW'(INOK_ON_DIP_MAX_MS / 2);
  localparam logic [MSW-1:0] MAIN_HOLD_CNT = MSW'(INOK_V1_MIN_MS + V1_DROP_MIN_MS - INOK_V1_MIN_MS);
  localparam logic [MSW-1:0] SB_HOLD_CNT = MSW'(INOK_VSB_MIN_MS + VSB_DROP_MIN_MS - INOK_VSB_MIN_MS);
  localparam logic [MSW-1:0] OFF_CNT = MSW'((OFF_MIN_MS + OFF_MAX_MS) / 2 - VSB_DROP_MIN_MS);
  localparam logic [MSW-1:0] PSON_ON_CNT = MSW'((PSON_ON_MIN_MS + PSON_ON_MAX_MS) / 2);
  localparam logic [MSW-1:0] PWOK_ON_CNT = MSW'((PWOK_ON_MIN_MS + PWOK_ON_MAX_MS) / 2);
  localparam logic [MSW-1:0] BLINK_CNT = MSW'(BLINK_PERIOD_MS);
  localparam logic [MSW-1:0] BLINK_HALF = MSW'(BLINK_PERIOD_MS / 2);
  localparam logic [MSW-1:0] BLINK_2_3 = MSW'(BLINK_PERIOD_MS * 2 / 3);

  localparam logic [7:0] SHARE_TRIM_MAX_MV = 8'hFA;

  // Pin vector positions
  localparam int IN_EN_N    = 0;
  localparam int IN_KILL_N  = 1;
  localparam int IN_RANGE   = 2;
  localparam int IN_MAIN_OK = 3;
  localparam int IN_SB_OK   = 4;
  localparam int IN_FLT_LSB = 5;
  localparam int N_FLT      = 4;
  localparam int IN_OT_WARN = 9;
  localparam int IN_FAN     = 10;
  localparam int IN_LARGEST = 11;
  localparam int N_IN       = 12;
  localparam logic [N_IN-1:0] PIN_RST = 12'h003;

  // Register map
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL  = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STAT  = 8'h04;
  localparam logic [ADDR_W-1:0] REG_FAULT = 8'h08;
  localparam int CTRL_MAIN_INH = 0;
  localparam logic CTRL_RST = 1'b0;
  localparam int STB_IG     = 0;
  localparam int STB_PG     = 1;
  localparam int STB_MAIN   = 2;
  localparam int STB_SB     = 3;
  localparam int STB_MASTER = 4;
  localparam int STB_ST     = 5;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    PS_OFF  = 2'b00,
    PS_RUN  = 2'b01,
    PS_HOLD = 2'b10,
    PS_WAIT = 2'b11
  } pwr_state_t;

  typedef enum logic [2:0] {
    LP_OFF    = 3'b000,
    LP_GREEN  = 3'b001,
    LP_BLINKY = 3'b010,
    LP_YELLOW = 3'b011,
    LP_YG21   = 3'b100,
    LP_YG11   = 3'b101
  } led_pat_t;
endpackage : psu_pkg

//--- pin_sync.sv
`timescale 1ns/10ps
module pin_sync #(
  parameter int              W       = 1,
  parameter logic [W-1:0]    RST_VAL = '0
) (
  input  wire logic         aclk,    // System clock
  input  wire logic         aresetn, // Sync reset, active low
  input  wire logic [W-1:0] d,       // Asynchronous pins
  output logic      [W-1:0] q        // Synchronised pins
);
  logic [W-1:0] meta_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= RST_VAL;
      q      <= RST_VAL;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : pin_sync

//--- ms_tick.sv
`timescale 1ns/10ps
module ms_tick #(
  parameter int CYC = 200000
) (
  input  wire logic aclk,    // System clock
  input  wire logic aresetn, // Sync reset, active low
  output logic      tick     // One-cycle pulse per period
);
  localparam int W = $clog2(CYC);
  logic [W-1:0] cnt_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end else if (cnt_r == W'(CYC - 1)) begin
      cnt_r <= '0;
      tick  <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 1'b1;
      tick  <= 1'b0;
    end
  end
endmodule : ms_tick

//--- psu_status_sequencer.sv
`timescale 1ns/10ps
// Summary of operation
// - AC LED solid green while input in range, off on undervoltage.
// - Bicolour DC LED reports output state; solid green in normal operation.
// - Solid yellow after temperature or rail voltage/current shutdown.
// - Yellow/green blink 2:1 during over temperature warning unless outputs_good_n asserted.
// - Yellow/green blink 1:1 on minor fan regulation error unless outputs_good_n asserted.
// - DC LED conditions tested in fixed priority, first match wins.
// - Main rail off at once when unplug_kill_n goes inactive.
// - Standby rail stays enabled whatever unplug_kill_n does.
// - Start on its own when input in range and output_enable_n low.
// - input_good_n asserted only while input usable.
// - input_good_n asserted within 1800 ms at start, 0-100 ms after dip.
// - input_good_n drops 12 ms before main, 40 ms before standby (documented minimum 7 and 27 ms).
// - Rail held off 1000-1200 ms after input-loss switch-off.
// - Main enabled while output_enable_n low; pulled-up default is off.
// - Toggling output_enable_n clears all latched faults.
// - Main on 190-220 ms after enable low, off within 100 ms.
// - outputs_good_n asserted only with both rails in regulation.
// - outputs_good_n asserted 250-350 ms after main regulates.
// - outputs_good_n released within 5 ms of main leaving regulation.
// - share_bus disconnected on fault or main rail off.
// - Largest-current unit is share master; slaves trim at most 250 mV.
// - outputs_good_n released in standby or after any rail fault.
module psu_status_sequencer #(
  parameter int CYC_PER_MS = psu_pkg::CYC_PER_MS
) (
  input  wire logic                        aclk,              // 200 MHz clock
  input  wire logic                        aresetn,           // Sync reset, active low
  input  wire logic                        output_enable_n,   // Main enable pin
  input  wire logic                        unplug_kill_n,     // Unplug kill pin
  input  wire logic                        input_in_range,    // Line monitor: input usable
  input  wire logic                        main_in_reg,       // Main rail in regulation
  input  wire logic                        standby_in_reg,    // Standby rail in regulation
  input  wire logic [psu_pkg::N_FLT-1:0]   shutdown_in,       // OT, OV, UV, OC shutdown
  input  wire logic                        ot_warning,        // Over temperature warning
  input  wire logic                        fan_err_minor,     // Fan error 5..15 %
  input  wire logic                        share_largest,     // Own current is largest
  input  wire logic [7:0]                  share_trim_req,    // Slave trim request, mV
  input  wire logic                        input_good_n_i,    // Pin readback
  output logic                             input_good_n_o,    // Pin drive level
  output logic                             input_good_n_oe_n, // Low while pulling
  input  wire logic                        outputs_good_n_i,  // Pin readback
  output logic                             outputs_good_n_o,  // Pin drive level
  output logic                             outputs_good_n_oe_n, // Low while pulling
  output logic                             inserted_n,        // Presence pin level
  output logic                             main_rail_en,      // Main rail enable
  output logic                             standby_rail_en,   // Standby rail enable
  output logic                             share_connect,     // share_bus switch closed
  output logic                             share_master,      // Acting as share master
  output logic [7:0]                       share_trim_mv,     // Slave voltage raise, mV
  output logic                             ac_led_green,      // AC LED
  output logic                             dc_led_green,      // DC LED green
  output logic                             dc_led_yellow,     // DC LED yellow
  input  wire logic [psu_pkg::ADDR_W-1:0]  s_axi_awaddr,      // AXI write address
  input  wire logic                        s_axi_awvalid,     // AXI
  output logic                             s_axi_awready,     // AXI
  input  wire logic [31:0]                 s_axi_wdata,       // AXI write data
  input  wire logic [3:0]                  s_axi_wstrb,       // AXI byte strobes
  input  wire logic                        s_axi_wvalid,      // AXI
  output logic                             s_axi_wready,      // AXI
  output logic [1:0]                       s_axi_bresp,       // AXI
  output logic                             s_axi_bvalid,      // AXI
  input  wire logic                        s_axi_bready,      // AXI
  input  wire logic [psu_pkg::ADDR_W-1:0]  s_axi_araddr,      // AXI read address
  input  wire logic                        s_axi_arvalid,     // AXI
  output logic                             s_axi_arready,     // AXI
  output logic [31:0]                      s_axi_rdata,       // AXI read data
  output logic [1:0]                       s_axi_rresp,       // AXI
  output logic                             s_axi_rvalid,      // AXI
  input  wire logic                        s_axi_rready       // AXI
);
  import psu_pkg::*;

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
    return (a == REG_CTRL) || (a == REG_STAT) || (a == REG_FAULT);
  endfunction : reg_hit

  logic [N_IN-1:0]  pin_raw;
  logic [N_IN-1:0]  pin_s;
  logic             tick;
  logic             en_n, kill_n, in_ok, main_ok, sb_ok;
  logic [N_FLT-1:0] flt_in;
  logic             en_n_d_r;
  logic             en_toggle;
  logic [N_FLT-1:0] fault_lat_r;
  logic             fault_any;
  logic             ctrl_inh_r;
  pwr_state_t       state_r;
  logic [MSW-1:0]   tmr_r;
  logic [MSW-1:0]   ig_cnt_r;
  logic [MSW-1:0]   pon_cnt_r;
  logic [MSW-1:0]   pg_cnt_r;
  logic [MSW-1:0]   blink_r;
  logic             main_req, pon_done, rail_ok, sb_on, pg_cond;
  logic             ig_r, pg_r, main_en_r, sb_en_r;
  led_pat_t         pat;

  assign pin_raw = {share_largest, fan_err_minor, ot_warning, shutdown_in,
                    standby_in_reg, main_in_reg, input_in_range, unplug_kill_n, output_enable_n};

  pin_sync #(.W(N_IN), .RST_VAL(PIN_RST)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (pin_raw),
    .q       (pin_s)
  );

  ms_tick #(.CYC(CYC_PER_MS)) u_tick (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (tick)
  );

  assign en_n      = pin_s[IN_EN_N];
  assign kill_n    = pin_s[IN_KILL_N];
  assign in_ok     = pin_s[IN_RANGE];
  assign main_ok   = pin_s[IN_MAIN_OK];
  assign sb_ok     = pin_s[IN_SB_OK];
  assign flt_in    = pin_s[IN_FLT_LSB +: N_FLT];
  assign en_toggle = en_n != en_n_d_r;
  assign fault_any = |fault_lat_r;

  // Fault latch; a new fault wins over the clearing toggle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_n_d_r    <= 1'b1;
      fault_lat_r <= '0;
    end else begin
      en_n_d_r    <= en_n;
      fault_lat_r <= (fault_lat_r & {N_FLT{~en_toggle}}) | flt_in;
    end
  end

  // Input power state: run, ride-through, forced off time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= PS_OFF;
      tmr_r   <= '0;
    end else begin
      case (state_r)
        PS_OFF:  if (in_ok) state_r <= PS_RUN;
        PS_RUN: begin
          tmr_r <= '0;
          if (!in_ok) state_r <= PS_HOLD;
        end
        PS_HOLD: begin
          if (in_ok && tmr_r < MAIN_HOLD_CNT) begin
            state_r <= PS_RUN;
          end else if (tick) begin
            tmr_r <= tmr_r + 1'b1;
            if (tmr_r == SB_HOLD_CNT - 1'b1) begin
              state_r <= PS_WAIT;
              tmr_r   <= '0;
            end
          end
        end
        PS_WAIT: begin
          if (tick) tmr_r <= tmr_r + 1'b1;
          if (tick && tmr_r == OFF_CNT - 1'b1) state_r <= PS_OFF;
        end
        default: state_r <= PS_OFF;
      endcase
    end
  end

  assign rail_ok = (state_r == PS_RUN) || (state_r == PS_HOLD && tmr_r < MAIN_HOLD_CNT);
  assign sb_on   = (state_r == PS_RUN) || (state_r == PS_HOLD);

  // Main turn-on delay from enable
  assign main_req = !en_n && !kill_n && !fault_any && !ctrl_inh_r;
  assign pon_done = pon_cnt_r == PSON_ON_CNT;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pon_cnt_r <= '0;
    end else if (!main_req) begin
      pon_cnt_r <= '0;
    end else if (tick && !pon_done) begin
      pon_cnt_r <= pon_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      main_en_r <= 1'b0;
      sb_en_r   <= 1'b0;
    end else begin
      main_en_r <= main_req && pon_done && rail_ok;
      sb_en_r   <= sb_on;
    end
  end

  // Input good: drops at once, returns after a fixed settle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ig_cnt_r <= '0;
      ig_r     <= 1'b0;
    end else if (!in_ok) begin
      ig_cnt_r <= '0;
      ig_r     <= 1'b0;
    end else begin
      if (tick && ig_cnt_r != INOK_ON_CNT) ig_cnt_r <= ig_cnt_r + 1'b1;
      ig_r <= ig_cnt_r == INOK_ON_CNT;
    end
  end

  // Outputs good
  assign pg_cond = main_en_r && sb_en_r && main_ok && sb_ok && !fault_any;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pg_cnt_r <= '0;
      pg_r     <= 1'b0;
    end else if (!pg_cond) begin
      pg_cnt_r <= '0;
      pg_r     <= 1'b0;
    end else begin
      if (tick && pg_cnt_r != PWOK_ON_CNT) pg_cnt_r <= pg_cnt_r + 1'b1;
      pg_r <= pg_cnt_r == PWOK_ON_CNT;
    end
  end

  // Open-drain status pins pull low when asserted
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      input_good_n_o      <= 1'b0;
      input_good_n_oe_n   <= 1'b1;
      outputs_good_n_o    <= 1'b0;
      outputs_good_n_oe_n <= 1'b1;
      inserted_n          <= 1'b0;
    end else begin
      input_good_n_o      <= 1'b0;
      input_good_n_oe_n   <= !ig_r;
      outputs_good_n_o    <= 1'b0;
      outputs_good_n_oe_n <= !pg_r;
      inserted_n          <= 1'b0;
    end
  end

  assign main_rail_en    = main_en_r;
  assign standby_rail_en = sb_en_r;

  // Current share
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      share_connect <= 1'b0;
      share_master  <= 1'b0;
      share_trim_mv <= 8'h00;
    end else begin
      share_connect <= main_en_r && !fault_any;
      share_master  <= share_connect && pin_s[IN_LARGEST];
      if (!share_connect || pin_s[IN_LARGEST])
        share_trim_mv <= 8'h00;
      else if (share_trim_req > SHARE_TRIM_MAX_MV)
        share_trim_mv <= SHARE_TRIM_MAX_MV;
      else
        share_trim_mv <= share_trim_req;
    end
  end

  // Blink timebase
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blink_r <= '0;
    end else if (tick) begin
      blink_r <= (blink_r == BLINK_CNT - 1'b1) ? '0 : blink_r + 1'b1;
    end
  end

  // DC LED priority selection
  always_comb begin
    if (pg_r && !fault_any)
      pat = LP_GREEN;
    else if (en_n)
      pat = LP_BLINKY;
    else if (fault_any || (main_en_r && !main_ok) || (sb_en_r && !sb_ok))
      pat = LP_YELLOW;
    else if (pin_s[IN_OT_WARN])
      pat = LP_YG21;
    else if (pin_s[IN_FAN])
      pat = LP_YG11;
    else
      pat = LP_OFF;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ac_led_green  <= 1'b0;
      dc_led_green  <= 1'b0;
      dc_led_yellow <= 1'b0;
    end else begin
      ac_led_green <= in_ok;
      case (pat)
        LP_GREEN:  {dc_led_yellow, dc_led_green} <= 2'h1;
        LP_BLINKY: {dc_led_yellow, dc_led_green} <= {blink_r < BLINK_HALF, 1'b0};
        LP_YELLOW: {dc_led_yellow, dc_led_green} <= 2'h2;
        LP_YG21:   {dc_led_yellow, dc_led_green} <= (blink_r < BLINK_2_3) ? 2'h2 : 2'h1;
        LP_YG11:   {dc_led_yellow, dc_led_green} <= (blink_r < BLINK_HALF) ? 2'h2 : 2'h1;
        default:   {dc_led_yellow, dc_led_green} <= 2'h0;
      endcase
    end
  end

  // AXI4-Lite write channel; address and data taken in either order
  logic              aw_hold_r, w_hold_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [31:0]       w_data_r;
  logic [3:0]        w_strb_r;
  logic              wr_fire;

  assign s_axi_awready = !aw_hold_r;
  assign s_axi_wready  = !w_hold_r;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire       = aw_hold_r && w_hold_r && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r    <= 1'b0;
      w_hold_r     <= 1'b0;
      aw_addr_r    <= '0;
      w_data_r     <= 32'h0;
      w_strb_r     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_hold_r) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_hold_r) begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= reg_hit(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      ctrl_inh_r <= CTRL_RST;
    else if (wr_fire && aw_addr_r == REG_CTRL && w_strb_r[0])
      ctrl_inh_r <= w_data_r[CTRL_MAIN_INH];
  end

  // Read channel
  logic [31:0] stat_w;

  always_comb begin
    stat_w                      = 32'h0;
    stat_w[STB_IG]              = ig_r;
    stat_w[STB_PG]              = pg_r;
    stat_w[STB_MAIN]            = main_en_r;
    stat_w[STB_SB]              = sb_en_r;
    stat_w[STB_MASTER]          = share_master;
    stat_w[STB_ST +: 2]         = state_r;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= reg_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr)
        REG_CTRL:  s_axi_rdata <= 32'(ctrl_inh_r) << CTRL_MAIN_INH;
        REG_STAT:  s_axi_rdata <= stat_w;
        REG_FAULT: s_axi_rdata <= 32'(fault_lat_r);
        default:   s_axi_rdata <= 32'h0;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_loss;
    $fell(in_ok) && state_r == PS_RUN && main_en_r && main_req;
  endsequence

  sequence s_ig_first;
    !ig_r && main_en_r && sb_en_r;
  endsequence

  a_kill_main_off: assert property (kill_n |=> !main_en_r)
    else $error("main rail on with unplug kill inactive");
  a_standby_indep: assert property ($rose(kill_n) && state_r == PS_RUN |=> sb_en_r)
    else $error("standby dropped by unplug kill");
  a_ig_range: assert property (!in_ok |=> !ig_r ##1 input_good_n_oe_n)
    else $error("input good asserted without usable input");
  a_ig_before_rails: assert property (s_loss |=> s_ig_first)
    else $error("rail dropped before input good released");
  a_enable_off: assert property (en_n |=> !main_en_r)
    else $error("main rail on while enable high");
  a_fault_clear: assert property (en_toggle && flt_in == '0 |=> fault_lat_r == '0)
    else $error("latched fault not cleared by enable toggle");
  a_main_delay: assert property ($rose(main_en_r) |-> $past(pon_cnt_r) == PSON_ON_CNT)
    else $error("main rail on before turn-on delay");
  a_pg_rails: assert property (!main_ok || !sb_ok |=> !pg_r)
    else $error("outputs good with rail out of regulation");
  a_pg_delay: assert property ($rose(pg_r) |-> $past(pg_cnt_r) == PWOK_ON_CNT)
    else $error("outputs good early");
  a_share_off: assert property (!main_en_r || fault_any |=> !share_connect)
    else $error("share bus connected while off or faulted");
  a_fault_yellow: assert property (fault_any && !en_n |=> dc_led_yellow && !dc_led_green)
    else $error("fault not shown solid yellow");
  a_ac_led: assert property (##1 ac_led_green == $past(in_ok))
    else $error("AC LED does not follow input range");
endmodule : psu_status_sequencer

//--- pdu_model.sv
`timescale 1ns/10ps
module pdu_model (
  input  wire logic en_req,     // Bench wants main on
  input  wire logic kill_req,   // Bench pulls supply
  input  wire logic ig_oe_n,    // Input good pull-down
  input  wire logic ig_o,       // Input good drive level
  input  wire logic pg_oe_n,    // Outputs good pull-down
  input  wire logic pg_o,       // Outputs good drive level
  input  wire logic inserted_n, // Presence pin
  output logic      enable_n,   // Enable pin
  output logic      kill_n,     // Kill pin
  output logic      ig_n,       // Input good wire
  output logic      pg_n,       // Outputs good wire
  output logic      present     // Supply seen in slot
);
  // Pulled-up wires
  assign ig_n = ig_oe_n ? 1'b1 : ig_o;
  assign pg_n = pg_oe_n ? 1'b1 : pg_o;
  assign enable_n = ~en_req;
  assign kill_n = kill_req;
  assign present = ~inserted_n;
endmodule : pdu_model

//--- psu_status_sequencer_tb.sv
`timescale 1ns/10ps
module psu_status_sequencer_tb;
  import psu_pkg::*;
  localparam int MS = 20;
  `define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; $display("BAD %0t %0h %0h", $time, a, b); end end
  logic aclk = 1'b0;
  logic aresetn, output_enable_n, unplug_kill_n, input_in_range, main_in_reg, standby_in_reg, ot_warning;
  logic fan_err_minor, share_largest, input_good_n_i, input_good_n_o, input_good_n_oe_n, outputs_good_n_i;
  logic outputs_good_n_o, outputs_good_n_oe_n, inserted_n, main_rail_en, standby_rail_en, share_connect;
  logic share_master, ac_led_green, dc_led_green, dc_led_yellow, en_req, kill_req, present;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0] shutdown_in, s_axi_wstrb;
  logic [7:0] share_trim_req, share_trim_mv, s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d, seed;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  int failures = 0;
  int n_checks = 0;
  int c, c2;
  always #2.5 aclk = ~aclk;
  psu_status_sequencer #(.CYC_PER_MS(MS)) i_dut (.*);
  pdu_model i_pdu (.en_req(en_req), .kill_req(kill_req), .ig_oe_n(input_good_n_oe_n), .ig_o(input_good_n_o),
    .pg_oe_n(outputs_good_n_oe_n), .pg_o(outputs_good_n_o), .inserted_n(inserted_n), .enable_n(output_enable_n),
    .kill_n(unplug_kill_n), .ig_n(input_good_n_i), .pg_n(outputs_good_n_i), .present(present));
  task end_sim;
    if (failures == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // 0 input good, 1 main, 2 outputs good, 3 standby
  function automatic logic sg(input int k);
    case (k)
      0: return ~input_good_n_i;
      1: return main_rail_en;
      2: return ~outputs_good_n_i;
      default: return standby_rail_en;
    endcase
  endfunction : sg
  task automatic wt(input int k, input logic v, input int mx, output int n);
    for (n = 0; n < mx && sg(k) !== v; n++) @(posedge aclk);
    if (n >= mx) begin
      failures++;
      end_sim();
    end
  endtask : wt
  task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50 && s_axi_bvalid !== 1'b1; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    if (n >= 50) begin
      failures++;
      end_sim();
    end
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50 && s_axi_rvalid !== 1'b1; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    if (n >= 50) begin
      failures++;
      end_sim();
    end
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axr
  initial begin
    {aresetn, en_req, kill_req, input_in_range, main_in_reg, standby_in_reg, ot_warning} <= '0;
    {fan_err_minor, share_largest, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= '0;
    {shutdown_in, share_trim_req, s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= '0;
    s_axi_wstrb <= 4'hF;
    seed = 32'hBE3E;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axr(8'h40, d, r);
    `CHK(r, RESP_SLVERR)
    axw(REG_CTRL, 32'h1, r);
    axr(REG_CTRL, d, r);
    `CHK(d[0], 1'b1)
    axw(REG_CTRL, 32'h0, r);
    `CHK(r, RESP_OKAY)
    input_in_range <= 1'b1;
    wt(0, 1'b1, MS * 1800, c);
    `CHK(c <= MS * 100 + 8, 1'b1)
    `CHK({ac_led_green, present, main_rail_en}, 3'b110)
    en_req <= 1'b1;
    wt(1, 1'b1, MS * 250, c);
    `CHK(c >= MS * 190 && c <= MS * 220 + 8, 1'b1)
    {main_in_reg, standby_in_reg, share_largest} <= 3'b111;
    wt(2, 1'b1, MS * 400, c);
    `CHK(c >= MS * 250 && c <= MS * 350 + 8, 1'b1)
    `CHK({dc_led_green, share_connect, share_master}, 3'b111)
    axr(REG_STAT, d, r);
    `CHK(d[2:0], 3'b111)
    share_largest <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      d = (i == 0) ? 32'hFF : seed;
      share_trim_req <= d[7:0];
      repeat (6) @(posedge aclk);
      `CHK(share_trim_mv, (d[7:0] > SHARE_TRIM_MAX_MV) ? SHARE_TRIM_MAX_MV : d[7:0])
    end
    for (int i = 0; i < 4; i++) begin
      shutdown_in <= 4'h1 << i;
      wt(2, 1'b0, MS * 5 + 8, c);
      repeat (4) @(posedge aclk);
      `CHK({main_rail_en, dc_led_yellow, share_connect}, 3'b010)
      axr(REG_FAULT, d, r);
      `CHK(d[3:0], 4'h1 << i)
      shutdown_in <= '0;
      en_req <= 1'b0;
      repeat (8) @(posedge aclk);
      en_req <= 1'b1;
      wt(2, 1'b1, MS * 600, c);
    end
    kill_req <= 1'b1;
    wt(1, 1'b0, 8, c);
    `CHK(standby_rail_en, 1'b1)
    kill_req <= 1'b0;
    ot_warning <= 1'b1;
    repeat (8) @(posedge aclk);
    `CHK(dc_led_yellow ^ dc_led_green, 1'b1)
    {ot_warning, fan_err_minor} <= 2'b01;
    repeat (8) @(posedge aclk);
    `CHK(dc_led_yellow ^ dc_led_green, 1'b1)
    fan_err_minor <= 1'b0;
    wt(1, 1'b1, MS * 250, c);
    input_in_range <= 1'b0;
    wt(0, 1'b0, 8, c);
    wt(1, 1'b0, MS * 300, c);
    `CHK(c >= MS * 7, 1'b1)
    wt(3, 1'b0, MS * 300, c2);
    `CHK(c + c2 >= MS * 27, 1'b1)
    input_in_range <= 1'b1;
    wt(3, 1'b1, MS * 1300, c);
    `CHK(c >= MS * 1000 && c <= MS * 1200 + 8, 1'b1)
    end_sim();
  end
endmodule : psu_status_sequencer_tb
